/* dtc_defines.svh */
/*
 * constants for the deinterleaver tap capability check
 * assumes: included by the package and by the design module
 */
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
`define DTC_UNIT_BITS 126
`define DTC_TAPS 48
`define DTC_LAST_TAP 6'h2f
`define DTC_CAP_LOW 20'h01980
`define DTC_CAP_HIGH 20'h66000
`define DTC_MULT_MIN 6'h01
`define DTC_MULT_MAX 6'h3f
`define DTC_RATE_SCALE 11'h030
`endif

/* dtc_pkg.sv */
/*
 * types shared by the tap capability check
 * assumes: dtc_defines.svh on the include path
 */
`include "dtc_defines.svh"
package dtc_pkg;
	// parameter set from the signalling parser, one-cycle strobe
	typedef struct packed {
		logic valid;
		logic class_high; // higher memory class receiver
		logic [5:0] multiplier; // common tap multiplier
		logic [7:0] slice_distance; // frames between slices
		logic [3:0] rate_num; // code rate numerator
		logic [3:0] rate_den; // code rate denominator
	} dtc_cfg_t;
	// one code-word fragment from the channel
	typedef struct packed {
		logic valid;
		logic [5:0] tap;
		logic [`DTC_UNIT_BITS-1:0] data;
	} dtc_frag_t;
	// one reordered fragment to the turbo decoder
	typedef struct packed {
		logic valid;
		logic last;
		logic [5:0] tap;
		logic [`DTC_UNIT_BITS-1:0] data;
	} dtc_word_t;
	// status for host software
	typedef struct packed {
		logic judged; // a verdict is available
		logic undecodable;
		logic [5:0] discarded; // taps dropped
	} dtc_status_t;
	typedef enum {DTC_IDLE, DTC_DERIVE, DTC_JUDGE, DTC_COLLECT, DTC_SEND}
		dtc_state_t;
endpackage

/* dtc_tap_check.sv */
/*
 * tap capability check and fragment reassembly for the time deinterleaver
 * assumes: parser gives a cfg strobe, fragments arrive only while
 * frag_ready is high, the decoder takes one word per cycle
 */
`include "dtc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dtc_tap_check (
	input wire logic ref_clk,
	input wire logic rst,
	input wire dtc_pkg::dtc_cfg_t cfg,
	input wire dtc_pkg::dtc_frag_t frag,
	output logic frag_ready,
	output dtc_pkg::dtc_word_t word,
	output dtc_pkg::dtc_status_t status
);
	// tap index lies among the retained taps
	function automatic logic tap_kept(input logic [5:0] tap,
		input logic [6:0] kept);
		tap_kept = ({1'b0, tap} < kept);
	endfunction

	dtc_pkg::dtc_state_t state, next_state;
	dtc_pkg::dtc_cfg_t held, next_held; // parameters of this signal
	logic [5:0] idx, next_idx; // tap under derivation or send pointer
	logic [19:0] delay, next_delay; // delay of tap idx in units
	logic [6:0] kept, next_kept; // taps that fit memory
	logic [`DTC_TAPS-1:0] have, next_have; // fragments present
	logic [`DTC_UNIT_BITS-1:0] store [`DTC_TAPS]; // fragment storage
	logic [`DTC_UNIT_BITS-1:0] next_store [`DTC_TAPS];
	logic next_frag_ready;
	dtc_pkg::dtc_word_t next_word;
	dtc_pkg::dtc_status_t next_status;
	logic [19:0] cap; // memory ceiling of this class
	logic [13:0] step; // delay increment between taps
	logic [`DTC_TAPS-1:0] keep_mask; // taps that must arrive
	logic rate_ok, mult_ok;

	// ceiling per class; the increment scales with both parameters
	assign cap = held.class_high ? `DTC_CAP_HIGH : `DTC_CAP_LOW;
	assign step = {8'h00, held.multiplier} * {6'h00, held.slice_distance};
	assign mult_ok = (held.multiplier >= `DTC_MULT_MIN)
		&& (held.multiplier <= `DTC_MULT_MAX);
	// rate/(kept/48) < 1  <=>  rate_num*48 < rate_den*kept
	assign rate_ok = ({7'h00, held.rate_num} * `DTC_RATE_SCALE)
		< ({7'h00, held.rate_den} * {4'h0, kept});

	// mask of taps whose fragments are awaited
	genvar g;
	generate
		for (g = 0; g < `DTC_TAPS; g = g + 1) begin : gen_mask
			assign keep_mask[g] = tap_kept(6'(g), kept);
		end
	endgenerate

	// sequencing: derive, judge, collect, send
	always_comb begin
		next_state = state;
		next_held = held;
		next_idx = idx;
		next_delay = delay;
		next_kept = kept;
		next_have = have;
		next_store = store;
		next_frag_ready = 1'b0;
		next_word = '0;
		next_status = status;
		case (state)
			dtc_pkg::DTC_IDLE: begin
				if (cfg.valid) begin
					// new parameters restart the whole derivation
					next_held = cfg;
					next_idx = 6'h00;
					next_delay = 20'h00000;
					next_kept = 7'h00;
					next_status = '0;
					next_state = dtc_pkg::DTC_DERIVE;
				end
			end
			dtc_pkg::DTC_DERIVE: begin
				// all 48 delays are walked even after one overflows
				if (delay <= cap) begin
					next_kept = kept + 7'h01;
				end
				next_delay = delay + {6'h00, step};
				next_idx = idx + 6'h01;
				if (idx == `DTC_LAST_TAP) begin
					next_state = dtc_pkg::DTC_JUDGE;
				end
			end
			dtc_pkg::DTC_JUDGE: begin
				next_status.judged = 1'b1;
				next_status.discarded = 6'(7'd48 - kept);
				next_have = '0;
				if (mult_ok && rate_ok && (kept != 7'h00)) begin
					next_state = dtc_pkg::DTC_COLLECT;
					next_frag_ready = 1'b1;
				end else begin
					// nothing reaches the decoder for this signal
					next_status.undecodable = 1'b1;
					next_state = dtc_pkg::DTC_IDLE;
				end
			end
			dtc_pkg::DTC_COLLECT: begin
				next_frag_ready = 1'b1;
				// fragments above the kept taps are simply dropped
				if (frag.valid && frag_ready && tap_kept(frag.tap, kept)) begin
					next_store[frag.tap] = frag.data;
					next_have[frag.tap] = 1'b1;
				end
				if ((next_have & keep_mask) == keep_mask) begin
					next_frag_ready = 1'b0;
					next_idx = 6'h00;
					next_state = dtc_pkg::DTC_SEND;
				end
			end
			dtc_pkg::DTC_SEND: begin
				// tap order restores the original code-word order
				next_word.valid = 1'b1;
				next_word.tap = idx;
				next_word.data = store[idx];
				next_word.last = ({1'b0, idx} == kept - 7'h01);
				next_idx = idx + 6'h01;
				if (next_word.last) begin
					next_have = '0;
					next_state = dtc_pkg::DTC_COLLECT;
					next_frag_ready = 1'b1;
				end
			end
			default: begin
				next_state = dtc_pkg::DTC_IDLE;
			end
		endcase
		// a new parameter set aborts any code word in flight
		if (cfg.valid && state != dtc_pkg::DTC_IDLE) begin
			next_state = dtc_pkg::DTC_IDLE;
			next_frag_ready = 1'b0;
		end
	end

	// storage kept out of reset to save area; have gates its use
	always_ff @(posedge ref_clk) begin
		store <= next_store;
	end

	// control registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= dtc_pkg::DTC_IDLE;
			held <= '0;
			idx <= 6'h00;
			delay <= 20'h00000;
			kept <= 7'h00;
			have <= '0;
			frag_ready <= 1'b0;
			word <= '0;
			status <= '0;
		end else begin
			state <= next_state;
			held <= next_held;
			idx <= next_idx;
			delay <= next_delay;
			kept <= next_kept;
			have <= next_have;
			frag_ready <= next_frag_ready;
			word <= next_word;
			status <= next_status;
		end
	end

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	word_in_kept_a: assert property (word.valid |-> tap_kept(word.tap, kept))
		else $error("word tap outside kept range");
	kept_cap_a: assert property (state == dtc_pkg::DTC_JUDGE
		|-> kept <= 7'd48)
		else $error("more than 48 taps kept");
	discard_count_a: assert property (state == dtc_pkg::DTC_JUDGE
		|=> status.discarded == 6'(7'd48 - kept))
		else $error("discarded count wrong");
	rate_gate_a: assert property (state == dtc_pkg::DTC_JUDGE && !rate_ok
		&& !cfg.valid |=> status.undecodable)
		else $error("rate failure not flagged");
	decode_gate_a: assert property (word.valid |-> !status.undecodable)
		else $error("word sent for undecodable signal");
	// only a new parameter set may cut the 48-step walk short
	derive_len_a: assert property (state == dtc_pkg::DTC_DERIVE
		&& idx != `DTC_LAST_TAP && !cfg.valid
		|=> state == dtc_pkg::DTC_DERIVE
		&& idx == $past(idx) + 6'h01)
		else $error("derivation cut short");
	low_cap_a: assert property (state == dtc_pkg::DTC_DERIVE
		&& !held.class_high && delay > `DTC_CAP_LOW && !cfg.valid
		|=> $stable(kept))
		else $error("low class kept oversize tap");
	high_cap_a: assert property (state == dtc_pkg::DTC_DERIVE
		&& held.class_high && delay > `DTC_CAP_HIGH && !cfg.valid
		|=> $stable(kept))
		else $error("high class kept oversize tap");
	// a tap inside the ceiling must be counted, the other half of the caps
	kept_grow_a: assert property (state == dtc_pkg::DTC_DERIVE
		&& delay <= cap && !cfg.valid
		|=> kept == $past(kept) + 7'h01)
		else $error("tap within ceiling not kept");
	// an abort in mid-send legally ends the word stream early
	send_order_a: assert property (word.valid && !word.last
		&& state == dtc_pkg::DTC_SEND && !cfg.valid
		|=> word.valid && word.tap == $past(word.tap) + 6'h01)
		else $error("words out of order");
	mult_range_a: assert property (state == dtc_pkg::DTC_JUDGE
		&& held.multiplier == 6'h00 && !cfg.valid |=> status.undecodable)
		else $error("zero multiplier accepted");

	judged_ok_c: cover property (state == dtc_pkg::DTC_JUDGE ##1
		state == dtc_pkg::DTC_COLLECT);
	judged_bad_c: cover property ($rose(status.undecodable));
	partial_c: cover property (word.last && kept < 7'd48);
	full_c: cover property (word.last && kept == 7'd48);
	abort_c: cover property (state == dtc_pkg::DTC_COLLECT && cfg.valid);
endmodule
`default_nettype wire

/* dtc_far_model.sv */
/* far side model: parameter strobes, fragments, decoder sink
 assumes one clock; it drives its outputs at the falling edge */
`timescale 1ns/1ps
`default_nettype none
module dtc_far_model (
	input wire logic ref_clk,
	input wire logic frag_ready,
	input wire dtc_pkg::dtc_word_t word,
	output dtc_pkg::dtc_cfg_t cfg,
	output dtc_pkg::dtc_frag_t frag
);
	logic [5:0] w_tap [64]; // words as the decoder took them
	logic [125:0] w_data [64];
	logic w_last [64];
	int w_n = 0;
	initial begin
		cfg = '0;
		frag = '0;
	end
	// one-cycle strobe; stale fields inverted after it
	// slice_distance also stands for the repetition period
	task automatic send_cfg(input logic h, input logic [5:0] m,
		input logic [7:0] d, input logic [3:0] rn, input logic [3:0] rd);
		@(negedge ref_clk);
		cfg = {1'b1, h, m, d, rn, rd};
		@(negedge ref_clk);
		cfg = {1'b0, ~cfg[22:0]};
		w_n = 0;
	endtask
	// one fragment per tap; waits up to 8 cycles for ready, then drives it anyway
	task automatic send_frag(input logic [5:0] t, input logic [125:0] v);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (!frag_ready && n < 8) begin
			@(negedge ref_clk);
			n++;
		end
		frag = {1'b1, t, v};
	endtask
	// a released line never shows the old value
	task automatic frag_idle();
		@(negedge ref_clk);
		frag = {1'b0, ~frag.tap, ~frag.data};
	endtask
	// decoder never stalls; the first 64 valid words after a parameter set are taken
	always @(posedge ref_clk) begin
		if (word.valid === 1'b1 && w_n < 64) begin
			w_tap[w_n] <= word.tap;
			w_data[w_n] <= word.data;
			w_last[w_n] <= word.last;
			w_n <= w_n + 1;
		end
	end
endmodule
`default_nettype wire

/* deinterleaver_tap_capability_check_tb.sv */
/* testbench of the tap capability check
 assumes the far side model drives cfg and frag */
`timescale 1ns/1ps
`default_nettype none
module deinterleaver_tap_capability_check_tb;
	logic ref_clk;
	logic rst;
	logic frag_ready;
	dtc_pkg::dtc_cfg_t cfg;
	dtc_pkg::dtc_frag_t frag;
	dtc_pkg::dtc_word_t word;
	dtc_pkg::dtc_status_t status;
	int fails = 0;
	int check_count = 0;
	dtc_tap_check dut (.ref_clk(ref_clk), .rst(rst), .cfg(cfg),
		.frag(frag), .frag_ready(frag_ready), .word(word), .status(status));
	dtc_far_model far (.ref_clk(ref_clk), .frag_ready(frag_ready),
		.word(word), .cfg(cfg), .frag(frag));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chk_bit(input string n, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic chk_vec(input string n, input logic [125:0] e,
		input logic [125:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// send a parameter set and judge the verdict; a busy block is aborted
	task automatic judge(input logic h, input logic [5:0] m,
		input logic [7:0] d, input logic [3:0] rn, input logic [3:0] rd);
		int k;
		int n;
		logic ok;
		k = 0;
		for (int i = 0; i < 48; i++)
			if (i * m * d <= (h ? 417792 : 6528)) k++;
		ok = !(m == 0 || k == 0 || rn * 48 >= rd * k);
		if (frag_ready === 1'b1) far.send_cfg(h, m, d, rn, rd);
		far.send_cfg(h, m, d, rn, rd);
		n = 1;
		while (status.judged !== 1'b1 && n < 60) begin
			@(negedge ref_clk);
			n++;
		end
		// 48 derive steps and one judge step after the accepting edge
		chk_vec("latency", 126'(50), 126'(n));
		chk_vec("discarded", 126'(48 - k), 126'(status.discarded));
		chk_bit("undecodable", !ok, status.undecodable);
		chk_bit("frag_ready", ok, frag_ready);
	endtask
	// words must come in tap order with last on the final tap
	task automatic collect(input int k);
		int n;
		n = 0;
		far.frag_idle();
		while (far.w_n < k && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		for (int i = 0; i < k; i++) begin
			chk_vec("word_tap", 126'(i), 126'(far.w_tap[i]));
			chk_vec("word_data", {21{6'(i)}}, far.w_data[i]);
			chk_bit("word_last", i == k - 1, far.w_last[i]);
		end
		@(negedge ref_clk);
		chk_bit("ready_again", 1'b1, frag_ready);
	endtask
	task automatic refuse();
		judge(1'b0, 6'h00, 8'h01, 4'h1, 4'h3);
		judge(1'b0, 6'h3f, 8'h08, 4'h1, 4'h3);
		far.send_frag(6'h00, '0);
		far.frag_idle();
		repeat (4) @(negedge ref_clk);
		chk_vec("words", 126'(0), 126'(far.w_n));
	endtask
	// rate 1/1 fails even with all taps kept
	task automatic edge_low();
		judge(1'b0, 6'h01, 8'h88, 4'h1, 4'h1);
		judge(1'b0, 6'h01, 8'h8b, 4'h1, 4'h1);
		// tap 34 lands exactly on the ceiling and is still kept
		judge(1'b0, 6'h01, 8'hc0, 4'h1, 4'h1);
	endtask
	// 27 taps kept; an out-of-range tap and an overwrite on the way
	task automatic high_partial();
		judge(1'b1, 6'h3f, 8'hff, 4'h1, 4'h2);
		far.send_frag(6'h1e, '0);
		far.send_frag(6'h05, '1);
		for (int t = 26; t >= 0; t--)
			far.send_frag(6'(t), {21{6'(t)}});
		collect(27);
	endtask
	task automatic full_low();
		judge(1'b0, 6'h01, 8'h01, 4'h1, 4'h3);
		for (int t = 47; t >= 0; t--)
			far.send_frag(6'(t), {21{6'(t)}});
		collect(48);
	endtask
	initial begin
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		refuse();
		edge_low();
		high_partial();
		full_low();
		end_of_test();
	end
	// all scenarios take well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
